// >>> design/wdrf_map.svh
// wdrf_map.svh: register indices, field positions, reset values, timing counts
// assumes: included by the watchdog design files and by the bench
`ifndef WDRF_MAP_SVH
`define WDRF_MAP_SVH

// ********************************
// register indices (byte address = index * 4)
// ********************************
`define WDRF_IDX_W 10
`define WDRF_IDX_RESET_CAUSE 10'h0ef
`define WDRF_IDX_WD_CMD 10'h0ff
`define WDRF_IDX_IRQ_STATUS 10'h100
`define WDRF_IDX_IRQ_MASK 10'h101

// ********************************
// command bytes and fields
// ********************************
`define WDRF_CMD_KICK 8'ha5
`define WDRF_CMD_DIS_FIRST 8'hde
`define WDRF_CMD_DIS_SECOND 8'had
`define WDRF_CMD_LOCK 8'hff
`define WDRF_CMD_SET_BIT 7
`define WDRF_STATUS_BIT 4
`define WDRF_POR_BIT 1
`define WDRF_SEL_RESET 3'h7
`define WDRF_IRQ_W 3
`define WDRF_IRQ_REFUSED 0
`define WDRF_IRQ_DISABLED 1
`define WDRF_IRQ_LOCKED 2

// ********************************
// timing
// ********************************
`define WDRF_CLK_PERIOD_NS 50
`define WDRF_DIS_WINDOW 3'h4
// timeout is 2**(base + 2*sel) clocks; base 6 is 4**3
`define WDRF_BASE_LOG2 6
`define WDRF_CNT_W 21

`endif

// >>> design/wdrf_pkg.sv
// wdrf_pkg: bus carriers and state types of the watchdog block
// assumes: AHB-Lite single word transfers from one master
package wdrf_pkg;

    typedef struct packed {
        logic hsel;
        logic [31:0] haddr;
        logic [1:0] htrans;
        logic hwrite;
        logic [2:0] hsize;
        logic [31:0] hwdata;
        logic hready;
    } wdrf_ahb_req_t;

    typedef struct packed {
        logic [31:0] hrdata;
        logic hreadyout;
        logic hresp;
    } wdrf_ahb_rsp_t;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [9:0] idx;
        logic [7:0] wdata;
    } wdrf_reg_acc_t;

    typedef enum logic [2:0] {
        WDRF_BUS_IDLE = 3'b001,
        WDRF_BUS_WAIT = 3'b010,
        WDRF_BUS_DONE = 3'b100
    } wdrf_bus_state_t;

endpackage

// >>> design/wdrf_timer.sv
// wdrf_timer: watchdog count with a power-of-two limit selectable in steps of four
// assumes: clear and run come from the register logic of the same clock
`timescale 1ns/1ns
module wdrf_timer #(
    parameter int CNT_W = 21,
    parameter int BASE_LOG2 = 6
) (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_reset_n,
    // control
    input wire logic i_run,
    input wire logic i_clear,
    input wire logic [2:0] i_sel,
    // event
    output logic o_expire
);

    logic [CNT_W-1:0] count;
    logic [CNT_W-1:0] last;

    if (CNT_W < BASE_LOG2 + 14 || BASE_LOG2 < 1) begin : g_bad
        $error("wdrf_timer: counter too narrow for the longest interval");
    end

    always_comb begin
        last = {CNT_W{1'b1}} >> (CNT_W - BASE_LOG2 - 2 * int'(i_sel));
    end

    // >= so that shortening the interval mid-count still expires at once
    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            count <= '0;
        end else if (i_clear) begin
            count <= '0;
        end else if (i_run) begin
            count <= (count >= last) ? '0 : count + 1'b1;
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            o_expire <= 1'b0;
        end else begin
            o_expire <= i_run && !i_clear && (count >= last);
        end
    end

    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_reset_n);

    property p_limit_expires;
        i_run && !i_clear && (count >= last) |=> o_expire;
    endproperty
    a_limit_expires: assert property (p_limit_expires) else $error("no expiry at limit");

    property p_no_early;
        o_expire |-> $past(count) >= $past(last) && $past(i_run);
    endproperty
    a_no_early: assert property (p_no_early) else $error("expiry before limit");

    property p_clear_zero;
        i_clear |=> count == '0 && !o_expire;
    endproperty
    a_clear_zero: assert property (p_clear_zero) else $error("restart did not zero");

endmodule

// >>> design/wdrf_ahb_slave.sv
// wdrf_ahb_slave: AHB-Lite slave front end, one wait state per transfer
// assumes: single word transfers; register data come back combinationally
`timescale 1ns/1ns
module wdrf_ahb_slave (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_reset_n,
    // bus
    input wdrf_pkg::wdrf_ahb_req_t i_bus,
    output wdrf_pkg::wdrf_ahb_rsp_t o_bus,
    // register side
    output wdrf_pkg::wdrf_reg_acc_t o_acc,
    input wire logic [7:0] i_rdata
);
    import wdrf_pkg::*;

    wdrf_bus_state_t state;
    logic take;
    logic is_write;
    logic idx_ok;
    logic [9:0] idx;

    assign take = i_bus.hsel && i_bus.htrans[1] && i_bus.hready;

    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            state <= WDRF_BUS_IDLE;
        end else begin
            unique case (state)
                WDRF_BUS_IDLE: state <= take ? WDRF_BUS_WAIT : WDRF_BUS_IDLE;
                WDRF_BUS_WAIT: state <= WDRF_BUS_DONE;
                WDRF_BUS_DONE: state <= take ? WDRF_BUS_WAIT : WDRF_BUS_IDLE;
            endcase
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            is_write <= 1'b0;
            idx_ok <= 1'b0;
            idx <= 10'h000;
        end else if (take) begin
            is_write <= i_bus.hwrite;
            idx_ok <= (i_bus.haddr[31:12] == 20'h00000) && (i_bus.haddr[1:0] == 2'h0);
            idx <= i_bus.haddr[11:2];
        end
    end

    // the wait state lets a write land before the next read samples
    always_comb begin
        o_acc.wr = (state == WDRF_BUS_WAIT) && is_write && idx_ok;
        o_acc.rd = (state == WDRF_BUS_WAIT) && !is_write && idx_ok;
        o_acc.idx = idx;
        o_acc.wdata = i_bus.hwdata[7:0];
    end

    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            o_bus <= '{hrdata: 32'h0, hreadyout: 1'b1, hresp: 1'b0};
        end else begin
            o_bus.hreadyout <= !take;
            o_bus.hresp <= 1'b0;
            if (state == WDRF_BUS_WAIT) begin
                o_bus.hrdata <= o_acc.rd ? {24'h0, i_rdata} : 32'h0;
            end
        end
    end

endmodule

// >>> design/wdrf_watchdog.sv
// wdrf_watchdog: software-serviced watchdog with reset cause and interrupts
// assumes: i_reset_n is the system reset; i_power_on marks a power-on one;
// the system resets the block soon after o_wdt_reset rises
//
// Chosen here: register access over AHB-Lite.
`timescale 1ns/1ns
`include "wdrf_map.svh"
module wdrf_watchdog #(
    parameter int CNT_W = `WDRF_CNT_W,
    parameter int BASE_LOG2 = `WDRF_BASE_LOG2
) (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_reset_n,
    // cause of the current reset
    input wire logic i_power_on,
    // register bus
    input wdrf_pkg::wdrf_ahb_req_t i_bus,
    output wdrf_pkg::wdrf_ahb_rsp_t o_bus,
    // system
    output logic o_wdt_reset,
    output logic o_irq
);
    import wdrf_pkg::*;

    // ********************************
    // decode helpers
    // ********************************
    function automatic logic hits(input wdrf_reg_acc_t a, input logic [9:0] i);
        hits = a.wr && (a.idx == i);
    endfunction

    function automatic logic cmd_is(input wdrf_reg_acc_t a, input logic [7:0] v);
        cmd_is = hits(a, `WDRF_IDX_WD_CMD) && (a.wdata == v);
    endfunction

    // ********************************
    // state
    // ********************************
    wdrf_reg_acc_t acc;
    logic [7:0] rdata;
    logic [2:0] sel;
    logic enabled;
    logic locked;
    logic [2:0] arm;
    logic por_flag;
    logic expire;
    logic kick;
    logic dis_ok;
    logic dis_bad;
    logic [`WDRF_IRQ_W-1:0] irq_ev;
    logic [`WDRF_IRQ_W-1:0] irq_status;
    logic [`WDRF_IRQ_W-1:0] irq_mask;

    wdrf_ahb_slave u_bus (
        .i_clk(i_clk),
        .i_reset_n(i_reset_n),
        .i_bus(i_bus),
        .o_bus(o_bus),
        .o_acc(acc),
        .i_rdata(rdata)
    );

    assign kick = cmd_is(acc, `WDRF_CMD_KICK);

    assign dis_ok = cmd_is(acc, `WDRF_CMD_DIS_SECOND) && (arm != 3'h0) && !locked;
    assign dis_bad = cmd_is(acc, `WDRF_CMD_DIS_SECOND) && !dis_ok;

    // ********************************
    // watchdog control
    // ********************************
    // longest interval default
    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            sel <= `WDRF_SEL_RESET;
        end else if (hits(acc, `WDRF_IDX_WD_CMD) && !acc.wdata[`WDRF_CMD_SET_BIT]) begin
            sel <= acc.wdata[2:0];
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            enabled <= 1'b1;
        end else if (kick) begin
            enabled <= 1'b1;
        end else if (dis_ok) begin
            enabled <= 1'b0;
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            locked <= 1'b0;
        end else if (cmd_is(acc, `WDRF_CMD_LOCK)) begin
            locked <= 1'b1;
        end
    end

    // disable window count
    // any other command byte breaks the pair
    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            arm <= 3'h0;
        end else if (hits(acc, `WDRF_IDX_WD_CMD)) begin
            arm <= (acc.wdata == `WDRF_CMD_DIS_FIRST) ? `WDRF_DIS_WINDOW : 3'h0;
        end else if (arm != 3'h0) begin
            arm <= arm - 3'h1;
        end
    end

    wdrf_timer #(
        .CNT_W(CNT_W),
        .BASE_LOG2(BASE_LOG2)
    ) u_timer (
        .i_clk(i_clk),
        .i_reset_n(i_reset_n),
        .i_run(enabled),
        .i_clear(kick),
        .i_sel(sel),
        .o_expire(expire)
    );

    // overflow holds reset request
    // held until the system reset arrives; no pin is driven here
    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            o_wdt_reset <= 1'b0;
        end else if (expire) begin
            o_wdt_reset <= 1'b1;
        end
    end

    // ********************************
    // reset cause
    // ********************************
    // power-on flag capture
    // sampled while reset is held, so it is settled at release
    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            por_flag <= i_power_on;
        end
    end

    // ********************************
    // interrupts
    // ********************************
    assign irq_ev[`WDRF_IRQ_REFUSED] = dis_bad;
    assign irq_ev[`WDRF_IRQ_DISABLED] = dis_ok;
    assign irq_ev[`WDRF_IRQ_LOCKED] = cmd_is(acc, `WDRF_CMD_LOCK);

    // set wins over a write-one clear in the same cycle
    for (genvar b = 0; b < `WDRF_IRQ_W; b++) begin : g_irq
        always_ff @(posedge i_clk) begin
            if (!i_reset_n) begin
                irq_status[b] <= 1'b0;
            end else if (irq_ev[b]) begin
                irq_status[b] <= 1'b1;
            end else if (hits(acc, `WDRF_IDX_IRQ_STATUS) && acc.wdata[b]) begin
                irq_status[b] <= 1'b0;
            end
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            irq_mask <= '0;
        end else if (hits(acc, `WDRF_IDX_IRQ_MASK)) begin
            irq_mask <= acc.wdata[`WDRF_IRQ_W-1:0];
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            o_irq <= 1'b0;
        end else begin
            o_irq <= |(irq_status & irq_mask);
        end
    end

    // ********************************
    // read data
    // ********************************
    // register readback: interval and status, reset cause, interrupt status and mask
    always_comb begin
        rdata = 8'h00;
        unique case (acc.idx)
            `WDRF_IDX_WD_CMD: begin
                rdata[2:0] = sel;
                rdata[`WDRF_STATUS_BIT] = enabled;
            end
            `WDRF_IDX_RESET_CAUSE: rdata[`WDRF_POR_BIT] = por_flag;
            `WDRF_IDX_IRQ_STATUS: rdata[`WDRF_IRQ_W-1:0] = irq_status;
            `WDRF_IDX_IRQ_MASK: rdata[`WDRF_IRQ_W-1:0] = irq_mask;
            default: rdata = 8'h00;
        endcase
    end

    // ********************************
    // checks
    // ********************************
    logic rd_cmd;
    logic rd_cause;
    assign rd_cmd = acc.rd && (acc.idx == `WDRF_IDX_WD_CMD);
    assign rd_cause = acc.rd && (acc.idx == `WDRF_IDX_RESET_CAUSE);

    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_reset_n);

    property p_read_sel;
        rd_cmd |=> o_bus.hrdata[2:0] == $past(sel) && o_bus.hreadyout;
    endproperty
    a_read_sel: assert property (p_read_sel) else $error("interval not read back");

    property p_read_status;
        rd_cmd |=> o_bus.hrdata[4] == $past(enabled) && o_bus.hrdata[7:5] == 3'h0;
    endproperty
    a_read_status: assert property (p_read_status) else $error("status bit wrong");

    property p_sel_after_reset;
        !$past(i_reset_n) |-> sel == 3'h7;
    endproperty
    a_sel_after_reset: assert property (p_sel_after_reset) else $error("interval not max");

    property p_on_after_reset;
        !$past(i_reset_n) |-> enabled && !locked && !o_wdt_reset;
    endproperty
    a_on_after_reset: assert property (p_on_after_reset) else $error("not enabled at reset");

    property p_kick;
        kick |=> enabled ##1 !expire;
    endproperty
    a_kick: assert property (p_kick) else $error("kick did not enable");

    // the second byte at the far end of the window, no command in between
    property p_disable_pair;
        cmd_is(acc, 8'hde) && !locked ##1 (!hits(acc, `WDRF_IDX_WD_CMD)) [*3]
            ##1 cmd_is(acc, 8'had) && !kick |=> !enabled;
    endproperty
    a_disable_pair: assert property (p_disable_pair) else $error("pair did not disable");

    property p_late_second;
        cmd_is(acc, 8'had) && arm == 3'h0 |=> enabled == $past(enabled) && irq_status[0];
    endproperty
    a_late_second: assert property (p_late_second) else $error("late disable taken");

    property p_lock;
        cmd_is(acc, 8'hff) |=> locked && enabled == $past(enabled) ##1 !$past(kick, 2);
    endproperty
    a_lock: assert property (p_lock) else $error("lock changed enable");

    property p_locked_holds;
        locked && enabled |=> enabled;
    endproperty
    a_locked_holds: assert property (p_locked_holds) else $error("locked dog disabled");

    property p_overflow;
        expire |=> o_wdt_reset ##1 o_wdt_reset;
    endproperty
    a_overflow: assert property (p_overflow) else $error("overflow not forwarded");

    property p_reset_cause;
        enabled ##0 $rose(o_wdt_reset) |-> $past(expire);
    endproperty
    a_reset_cause: assert property (p_reset_cause) else $error("reset without expiry");

    property p_por_read;
        rd_cause |=> o_bus.hrdata[1] == $past(por_flag) && o_bus.hrdata[0] == 1'b0;
    endproperty
    a_por_read: assert property (p_por_read) else $error("power-on flag misread");

    property p_irq;
        |(irq_status & irq_mask) |=> o_irq;
    endproperty
    a_irq: assert property (p_irq) else $error("interrupt not raised");

endmodule

// >>> tb/tb_top.sv
// tb_top: self-checking bench for the watchdog block over its register bus
// assumes: wdrf_pkg is compiled first; the bench acts as the only bus master
`timescale 1ns/1ns
`include "wdrf_map.svh"
module tb_top;
    import wdrf_pkg::*;

    // ********************************
    // clock, reset and bus signals
    // ********************************
    localparam logic [31:0] A_CAUSE = {20'h0, `WDRF_IDX_RESET_CAUSE, 2'b00};
    localparam logic [31:0] A_CMD = {20'h0, `WDRF_IDX_WD_CMD, 2'b00};
    localparam logic [31:0] A_STAT = {20'h0, `WDRF_IDX_IRQ_STATUS, 2'b00};
    localparam logic [31:0] A_MASK = {20'h0, `WDRF_IDX_IRQ_MASK, 2'b00};
    // short base so the longest interval stays inside the run: sel 2 gives 32 clocks
    localparam int BASE = 1;
    localparam int T_SEL2 = 32;

    logic i_clk;
    logic i_reset_n;
    logic i_power_on;
    logic o_wdt_reset;
    logic o_irq;
    wdrf_ahb_req_t drv;
    wdrf_ahb_req_t bus_in;
    wdrf_ahb_rsp_t bus_rsp;
    logic [31:0] exp_q[$];
    logic rd_wait;
    int mismatches;
    int n_tests;
    int seed;
    int cyc;
    int t0;

    always_comb begin
        bus_in = drv;
        bus_in.hready = bus_rsp.hreadyout;
    end

    wdrf_watchdog #(.CNT_W(21), .BASE_LOG2(BASE)) wdrf_watchdog_inst (
        .i_clk(i_clk),
        .i_reset_n(i_reset_n),
        .i_power_on(i_power_on),
        .i_bus(bus_in),
        .o_bus(bus_rsp),
        .o_wdt_reset(o_wdt_reset),
        .o_irq(o_irq)
    );

    initial begin
        i_clk = 1'b0;
        forever #25 i_clk = ~i_clk;
    end

    always @(posedge i_clk) cyc <= cyc + 1;

    // ********************************
    // reporting
    // ********************************
    task automatic print_verdict;
        if (mismatches == 0 && n_tests > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            mismatches++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // read data are compared against the oldest note when the wait ends
    always @(negedge i_clk) begin
        if (rd_wait && bus_rsp.hreadyout === 1'b1) begin
            rd_wait = 1'b0;
            check(bus_rsp.hrdata, exp_q.pop_front());
        end
    end

    // ********************************
    // bus tasks
    // ********************************
    // ends just after the rising edge at which hready was sampled high
    task automatic wait_rdy;
        int n;
        n = 0;
        @(negedge i_clk);
        while (bus_rsp.hreadyout !== 1'b1 && n < 50) begin
            n++;
            @(negedge i_clk);
        end
        if (n >= 50) begin
            mismatches++;
            print_verdict();
        end
        @(posedge i_clk);
    endtask

    task automatic addr_phase(input logic [31:0] a, input logic wr);
        drv.hsel <= 1'b1;
        drv.htrans <= 2'b10;
        drv.haddr <= a;
        drv.hwrite <= wr;
        drv.hsize <= 3'h2;
        wait_rdy();
        drv.hsel <= 1'b0;
        drv.htrans <= 2'b00;
    endtask

    task automatic wr(input logic [31:0] a, input logic [7:0] d);
        addr_phase(a, 1'b1);
        drv.hwdata <= {24'h0, d};
        wait_rdy();
    endtask

    task automatic rd(input logic [31:0] a, input logic [7:0] e);
        exp_q.push_back({24'h0, e});
        addr_phase(a, 1'b0);
        rd_wait = 1'b1;
        wait_rdy();
    endtask

    task automatic idle(input int n);
        repeat (n) @(posedge i_clk);
    endtask

    task automatic do_reset(input logic por);
        i_reset_n <= 1'b0;
        i_power_on <= por;
        idle(2);
        i_reset_n <= 1'b1;
        i_power_on <= 1'b0;
    endtask

    // time from the end of the kick transfer to the forced reset
    task automatic wait_wdt(input int exp);
        int n;
        n = 0;
        while (o_wdt_reset !== 1'b1 && n < 40000) begin
            n++;
            @(negedge i_clk);
        end
        if (n >= 40000) begin
            mismatches++;
            print_verdict();
        end
        check(cyc - t0, exp);
    endtask

    // ********************************
    // main sequence
    // ********************************
    initial begin
        drv = '0;
        i_reset_n = 1'b0;
        i_power_on = 1'b0;
        rd_wait = 1'b0;
        mismatches = 0;
        n_tests = 0;
        seed = 99;
        cyc = 0;
        do_reset(1'b1);
        rd(A_CMD, 8'h17);
        rd(A_CAUSE, 8'h02);
        rd(32'h0000_0000, 8'h00);
        rd(A_MASK, 8'h00);
        wr(A_MASK, 8'h07);
        // back to back with one spare cycle: pair lands four clocks apart
        wr(A_CMD, `WDRF_CMD_DIS_FIRST);
        idle(1);
        wr(A_CMD, `WDRF_CMD_DIS_SECOND);
        rd(A_CMD, 8'h07);
        check(o_irq, 1'b1);
        rd(A_STAT, 8'h02);
        wr(A_STAT, 8'h02);
        rd(A_STAT, 8'h00);
        check(o_irq, 1'b0);
        // interval field with random upper bits while the count is frozen
        for (int i = 0; i < 8; i++) begin
            wr(A_CMD, (8'($random(seed)) & 8'h78) | 8'(i));
            rd(A_CMD, 8'(i));
        end
        wr(A_CMD, 8'h00);
        idle(20);
        check(o_wdt_reset, 1'b0);
        wr(A_CMD, 8'h02);
        wr(A_CMD, `WDRF_CMD_KICK);
        rd(A_CMD, 8'h12);
        // one clock too late: the pair is five clocks apart and refused
        wr(A_CMD, `WDRF_CMD_DIS_FIRST);
        idle(2);
        wr(A_CMD, `WDRF_CMD_DIS_SECOND);
        rd(A_CMD, 8'h12);
        wr(A_CMD, `WDRF_CMD_KICK);
        rd(A_STAT, 8'h01);
        wr(A_STAT, 8'h01);
        // lock neither restarts nor lets a correct pair through
        wr(A_CMD, `WDRF_CMD_KICK);
        @(negedge i_clk);
        t0 = cyc;
        @(posedge i_clk);
        idle(12);
        wr(A_CMD, `WDRF_CMD_LOCK);
        wr(A_CMD, `WDRF_CMD_DIS_FIRST);
        idle(1);
        wr(A_CMD, `WDRF_CMD_DIS_SECOND);
        @(negedge i_clk);
        check(o_irq, 1'b1);
        wait_wdt(T_SEL2);
        @(posedge i_clk);
        do_reset(1'b0);
        check(o_wdt_reset, 1'b0);
        rd(A_CAUSE, 8'h00);
        rd(A_CMD, 8'h17);
        rd(A_MASK, 8'h00);
        wr(A_CMD, `WDRF_CMD_KICK);
        wr(A_CMD, 8'h02);
        for (int i = 0; i < 6; i++) begin
            idle(20);
            wr(A_CMD, `WDRF_CMD_KICK);
        end
        check(o_wdt_reset, 1'b0);
        @(negedge i_clk);
        t0 = cyc;
        wait_wdt(T_SEL2);
        check(o_wdt_reset, 1'b1);
        idle(2);
        print_verdict();
    end
endmodule
